// ==== rtl/spi_slave_defs.svh ====
// Constants of the serial slave byte shifter
// Overview of operation
// - Eight bits per transfer, full duplex, on the master's single serial clock.
// - Modes 0 and 1 sample on the leading edge and change on the trailing edge.
// - Modes 2 and 3 sample on the trailing edge and change on the leading edge.
// - Configurable LSB-first or MSB-first order for both shift directions.
// - Slave takes part only while enabled; clearing enable stops the engine.
// - Writing the transmit holding buffer loads it and clears transmit-empty.
// - Select falling edge copies holding buffer to shifter and presents first bit.
// - Each active clock edge pair shifts one bit out and one bit in.
// - After eight bits: shifter to receive buffer, reload shifter, set full and done.
// - With interrupt enabled, transfer-done raises the interrupt request.
// - A byte completed before the receive buffer is read sets overrun.
// - Status read clears done, overrun and request; request high masks further completion interrupts.
// - The master-in output is always driven, never high impedance.
// - Load-empty setting raises the interrupt once the holding buffer is copied.
// - Transmit-finished setting raises the interrupt at the last bit's sampling edge, the same point as receive-finished.
// - Firmware-driven select follows firmwareSelectControl; reset leaves select seen as deasserted.
// - Serial clock and select synchronised and filtered by default; double-rate and none settings both use the two-stage synchroniser.
// - Master-out picked from 16 sources; select from four inputs or firmware.
// - Status byte: done 0x20, overrun 0x40, transmit-empty 0x10, receive-full 0x08.
`ifndef SPI_SLAVE_DEFS_SVH
`define SPI_SLAVE_DEFS_SVH

`define SPI_BYTE_BITS 8
`define SPI_LAST_BIT 4'h7
`define SPI_TOP_INDEX 3'h7

`define STAT_DONE_BIT 5
`define STAT_OVERRUN_BIT 6
`define STAT_TX_EMPTY_BIT 4
`define STAT_RX_FULL_BIT 3

`define SYNC_SYSTEM 2'h0
`define SYNC_DOUBLE 2'h1
`define SYNC_NONE 2'h2

`define SS_SOURCE_FIRMWARE 3'h4

`define SYNC_SCLK 0
`define SYNC_SSN 1

`endif

// ==== rtl/spi_slave_pkg.sv ====
// Types of the serial slave byte shifter
package spi_slave_pkg;

   typedef enum logic [1:0] {
      ENGINE_IDLE = 2'b01,
      ENGINE_ACTIVE = 2'b10
   } engine_state_t;

   typedef enum logic [3:0] {
      IRQ_ON_TX_LOAD = 4'b0001,
      IRQ_ON_TX_FINISH = 4'b0010,
      IRQ_ON_RX_FINISH = 4'b0100,
      IRQ_ON_RX_HOLDING_FREE = 4'b1000
   } irq_mode_t;

   typedef struct packed {
      logic [1:0] sync1;
      logic [1:0] sync2;
      logic [1:0] sync3;
      logic [1:0] filt;
      logic lastSclk;
      logic lastSsN;
      logic [7:0] txHold;
      logic [7:0] shadow;
      logic [3:0] bitCnt;
      logic [7:0] rxData;
      logic miso;
      logic txEmpty;
      logic rxFull;
      logic done;
      logic overrun;
      logic irqReq;
      logic irq;
      engine_state_t state;
   } core_state_t;

   typedef struct packed {
      logic [7:0] rxShift;
   } link_state_t;

endpackage : spi_slave_pkg

// ==== rtl/rx_link_shifter.sv ====
// Receive shifter clocked by the master's serial clock
`timescale 1ns/1ps
`default_nettype none
module rx_link_shifter (
   // Link clock and frame clear
   input wire logic sampleClk,
   input wire logic linkClear,
   // Data and configuration
   input wire logic mosi,
   input wire logic lsbFirst,
   // Received bits
   output logic [7:0] rxWord
);
   import spi_slave_pkg::*;

   link_state_t q;
   link_state_t d;

   always_comb begin
      d = q;
      if (lsbFirst) begin
         d.rxShift = {mosi, q.rxShift[7:1]};
      end else begin
         d.rxShift = {q.rxShift[6:0], mosi};
      end
   end

   // Clock stands still outside frames, so the frame end clears the shifter
   always_ff @(posedge sampleClk or posedge linkClear) begin
      if (linkClear) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign rxWord = q.rxShift;

endmodule : rx_link_shifter
`default_nettype wire

// ==== rtl/spi_slave_byte_shifter.sv ====
// Serial peripheral slave with holding buffers, status flags and interrupt
`timescale 1ns/1ps
`default_nettype none
`include "spi_slave_defs.svh"
module spi_slave_byte_shifter #(
   parameter int MOSI_SOURCES = 16,
   parameter int SS_INPUTS = 4
) (
   // System clock and reset
   input wire logic clk,
   input wire logic reset,
   // Serial link
   input wire logic sclk,
   input wire logic [MOSI_SOURCES-1:0] mosiSources,
   input wire logic [SS_INPUTS-1:0] ssInputsN,
   output logic miso,
   // Configuration
   input wire logic enable,
   input wire logic [1:0] spiMode,
   input wire logic lsbFirst,
   input wire logic [1:0] inputSyncSelect,
   input wire logic [3:0] mosiSourceSel,
   input wire logic [2:0] ssSourceSel,
   input wire logic firmwareSelectControl,
   input wire logic intEnable,
   input wire spi_slave_pkg::irq_mode_t irqMode,
   // Software side
   input wire logic txWrite,
   input wire logic [7:0] txData,
   input wire logic rxRead,
   output logic [7:0] rxData,
   input wire logic statusRead,
   output logic [7:0] statusByte,
   output logic txEmpty,
   output logic rxFull,
   output logic transferDone,
   output logic overrun,
   output logic irq
);
   import spi_slave_pkg::*;

   core_state_t q;
   core_state_t d;
   logic ssNSel;
   logic mosiSel;
   logic sampleClk;
   logic linkClear;
   logic [7:0] rxWord;
   logic sclkUse;
   logic ssNUse;
   logic sampleEdge;
   logic changeEdge;
   logic ssFall;
   logic ssRise;

   // Picks the bit to present for a given position and order
   function automatic logic pickBit(input logic [7:0] byteIn, input logic [2:0] idx, input logic lsbMode);
      logic [2:0] pos;
      pos = lsbMode ? idx : (`SPI_TOP_INDEX - idx);
      return byteIn[pos];
   endfunction : pickBit

   // Input routing
   assign mosiSel = mosiSources[mosiSourceSel];
   always_comb begin
      if (ssSourceSel == `SS_SOURCE_FIRMWARE) begin
         ssNSel = firmwareSelectControl;
      end else if (ssSourceSel < 3'(SS_INPUTS)) begin
         ssNSel = ssInputsN[ssSourceSel[1:0]];
      end else begin
         ssNSel = 1'b1;
      end
   end

   // Sampling edge of the link clock for the selected mode
   assign sampleClk = sclk ^ (spiMode[0] ^ spiMode[1]);
   assign linkClear = ssNSel | ~enable;

   rx_link_shifter u_rx (
      .sampleClk(sampleClk),
      .linkClear(linkClear),
      .mosi(mosiSel),
      .lsbFirst(lsbFirst),
      .rxWord(rxWord)
   );

   // Synchronised views of the link clock and select
   always_comb begin
      if (inputSyncSelect == `SYNC_SYSTEM) begin
         sclkUse = q.filt[`SYNC_SCLK];
         ssNUse = q.filt[`SYNC_SSN];
      end else begin
         sclkUse = q.sync2[`SYNC_SCLK];
         ssNUse = q.sync2[`SYNC_SSN];
      end
   end

   assign sampleEdge = (sclkUse ^ spiMode[0] ^ spiMode[1]) & ~(q.lastSclk ^ spiMode[0] ^ spiMode[1]);
   assign changeEdge = ~(sclkUse ^ spiMode[0] ^ spiMode[1]) & (q.lastSclk ^ spiMode[0] ^ spiMode[1]);
   assign ssFall = q.lastSsN & ~ssNUse;
   assign ssRise = ~q.lastSsN & ssNUse;

   always_comb begin
      d = q;
      d.sync1 = {ssNSel, sclk};
      d.sync2 = q.sync1;
      d.sync3 = q.sync2;
      for (int i = 0; i < 2; i++) begin
         if (q.sync2[i] == q.sync3[i]) begin
            d.filt[i] = q.sync3[i];
         end
      end
      d.lastSclk = sclkUse;
      d.lastSsN = ssNUse;
      // Clears come first so that a same-cycle event wins
      if (statusRead) begin
         d.done = 1'b0;
         d.overrun = 1'b0;
         d.irqReq = 1'b0;
      end
      if (rxRead) begin
         d.rxFull = 1'b0;
      end
      unique case (q.state)
         ENGINE_IDLE: begin
            if (enable && ssFall) begin
               d.shadow = q.txHold;
               d.txEmpty = 1'b1;
               d.bitCnt = 4'h0;
               d.miso = pickBit(q.txHold, 3'h0, lsbFirst);
               d.state = ENGINE_ACTIVE;
            end
         end
         ENGINE_ACTIVE: begin
            if (!enable || ssRise) begin
               d.state = ENGINE_IDLE;
            end else if (sampleEdge) begin
               d.bitCnt = q.bitCnt + 4'h1;
               if (q.bitCnt == `SPI_LAST_BIT) begin
                  d.rxData = rxWord;
                  d.shadow = q.txHold;
                  d.txEmpty = 1'b1;
                  d.bitCnt = 4'h0;
                  d.rxFull = 1'b1;
                  d.done = 1'b1;
                  if (q.rxFull && !rxRead) begin
                     d.overrun = 1'b1;
                  end
                  if (!q.irqReq || statusRead) begin
                     d.irqReq = 1'b1;
                  end
               end
            end else if (changeEdge) begin
               d.miso = pickBit(q.shadow, q.bitCnt[2:0], lsbFirst);
            end
         end
      endcase
      // A write in the load cycle lands in the freed holding buffer
      if (txWrite) begin
         d.txHold = txData;
         d.txEmpty = 1'b0;
      end
      unique case (irqMode)
         IRQ_ON_TX_LOAD: d.irq = intEnable & d.txEmpty;
         IRQ_ON_TX_FINISH: d.irq = intEnable & d.irqReq;
         IRQ_ON_RX_FINISH: d.irq = intEnable & d.irqReq;
         IRQ_ON_RX_HOLDING_FREE: d.irq = intEnable & ~d.rxFull;
         default: d.irq = 1'b0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         q <= '0;
         q.sync1 <= 2'h3;
         q.sync2 <= 2'h3;
         q.sync3 <= 2'h3;
         q.filt <= 2'h3;
         q.lastSsN <= 1'b1;
         q.txEmpty <= 1'b1;
         q.state <= ENGINE_IDLE;
      end else begin
         q <= d;
      end
   end

   // Outputs
   assign miso = q.miso;
   assign rxData = q.rxData;
   assign txEmpty = q.txEmpty;
   assign rxFull = q.rxFull;
   assign transferDone = q.done;
   assign overrun = q.overrun;
   assign irq = q.irq;
   always_comb begin
      statusByte = 8'h00;
      statusByte[`STAT_DONE_BIT] = q.done;
      statusByte[`STAT_OVERRUN_BIT] = q.overrun;
      statusByte[`STAT_TX_EMPTY_BIT] = q.txEmpty;
      statusByte[`STAT_RX_FULL_BIT] = q.rxFull;
   end

endmodule : spi_slave_byte_shifter
`default_nettype wire

// ==== verif/spi_slave_props.sv ====
// Checker of the serial slave byte shifter ports
`timescale 1ns/1ps
`default_nettype none
module spi_slave_props (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Inputs
   input wire logic [3:0] ssInputsN,
   input wire logic [2:0] ssSourceSel,
   input wire logic enable,
   input wire logic intEnable,
   input wire spi_slave_pkg::irq_mode_t irqMode,
   input wire logic txWrite,
   input wire logic rxRead,
   input wire logic statusRead,
   // Outputs
   input wire logic [7:0] rxData,
   input wire logic [7:0] statusByte,
   input wire logic txEmpty,
   input wire logic rxFull,
   input wire logic transferDone,
   input wire logic overrun,
   input wire logic irq
);
   import spi_slave_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   logic idle;
   assign idle = ssSourceSel < 3'h4 && ssInputsN[ssSourceSel[1:0]];
   property p_reset; $fell(reset) |-> txEmpty && !rxFull && !transferDone && rxData == 8'h00; endproperty
   a_reset: assert property (p_reset) else $error("reset values");
   property p_tx_load; txWrite && idle |=> !txEmpty; endproperty
   a_tx_load: assert property (p_tx_load) else $error("tx empty kept");
   property p_stat_clr; statusRead && idle |=> !transferDone && !overrun; endproperty
   a_stat_clr: assert property (p_stat_clr) else $error("status kept");
   property p_rx_clr; rxRead && idle |=> !rxFull; endproperty
   a_rx_clr: assert property (p_rx_clr) else $error("rx full kept");
   property p_map; statusByte == {1'b0, overrun, transferDone, txEmpty, rxFull, 3'h0}; endproperty
   a_map: assert property (p_map) else $error("status byte map");
   property p_load_irq; (intEnable && irqMode == IRQ_ON_TX_LOAD && txEmpty) [*3] |-> irq; endproperty
   a_load_irq: assert property (p_load_irq) else $error("load irq");
   property p_fin_irq; intEnable && irqMode == IRQ_ON_RX_FINISH && $rose(transferDone) |-> ##[0:2] irq; endproperty
   a_fin_irq: assert property (p_fin_irq) else $error("finish irq");
   property p_off; (!enable) [*4] |-> !$rose(rxFull) && !$rose(transferDone); endproperty
   a_off: assert property (p_off) else $error("moved while off");
endmodule : spi_slave_props
`default_nettype wire

// ==== verif/spi_master_model.sv ====
// Behavioural master on the serial link
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
   // Serial link
   output logic sclk,
   output logic ssN,
   output logic mosi,
   input wire logic miso
);
   logic lclk = 1'b0;
   always #7.5 lclk = ~lclk;
   initial begin
      sclk = 1'b0;
      ssN = 1'b1;
      mosi = 1'b0;
   end
   task automatic half();
      repeat (17) @(posedge lclk);
   endtask : half
   task automatic frame(input logic [1:0] mode, input logic lsb, input int n, input logic [15:0] mo,
                        output logic [15:0] mi);
      int b;
      int k;
      int x;
      mi = 16'h0000;
      sclk = mode[0];
      half();
      ssN = 1'b0;
      repeat (20) @(posedge lclk);
      for (b = 0; b < n; b++) begin
         for (k = 0; k < 8; k++) begin
            x = 8 * b + (lsb ? k : 7 - k);
            if (!mode[1]) mosi = mo[x];
            half();
            sclk = ~mode[0];
            if (mode[1]) mosi = mo[x];
            else mi[x] = miso;
            half();
            sclk = mode[0];
            if (mode[1]) mi[x] = miso;
         end
      end
      half();
      ssN = 1'b1;
      mosi = ~mosi;
   endtask : frame
endmodule : spi_master_model
`default_nettype wire

// ==== verif/spi_slave_byte_shifter_bench.sv ====
// Self-checking bench of the serial slave byte shifter
`timescale 1ns/1ps
`default_nettype none
module spi_slave_byte_shifter_bench;
   import spi_slave_pkg::*;
   logic clk = 1'b0, reset = 1'b1, enable = 1'b1, lsbFirst = 1'b0, intEnable = 1'b1, doneLast = 1'b0;
   logic txWrite = 1'b0, rxRead = 1'b0, statusRead = 1'b0, fwMode = 1'b0, fwSel = 1'b0;
   logic [1:0] spiMode = 2'h0, inputSyncSelect = 2'h0, ssSel = 2'h0;
   logic [3:0] mosiSel = 4'h0, ssInputsN;
   logic [7:0] txData = 8'h00, tx, rxData, statusByte;
   logic [15:0] noise = 16'h0000, mo, mi, mosiSources;
   logic [31:0] seed = 32'h00013F69;
   irq_mode_t irqMode = IRQ_ON_TX_LOAD;
   logic sclk, ssN, mosi, miso, txEmpty, rxFull, transferDone, overrun, irq;
   logic [7:0] expQ [$];
   int n_fail = 0, checks_done = 0, cycles = 0, i;
   always #12.5 clk = ~clk;
   assign mosiSources = (noise & ~(16'h0001 << mosiSel)) | ({15'h0000, mosi} << mosiSel);
   assign ssInputsN = ~({3'h0, ~ssN} << ssSel);
   spi_master_model m (.sclk(sclk), .ssN(ssN), .mosi(mosi), .miso(miso));
   spi_slave_byte_shifter DUT (.clk(clk), .reset(reset), .sclk(sclk), .mosiSources(mosiSources),
      .ssInputsN(ssInputsN), .miso(miso), .enable(enable), .spiMode(spiMode), .lsbFirst(lsbFirst),
      .inputSyncSelect(inputSyncSelect), .mosiSourceSel(mosiSel), .ssSourceSel({fwMode, ssSel}),
      .firmwareSelectControl(fwSel), .intEnable(intEnable), .irqMode(irqMode), .txWrite(txWrite),
      .txData(txData), .rxRead(rxRead), .rxData(rxData), .statusRead(statusRead), .statusByte(statusByte),
      .txEmpty(txEmpty), .rxFull(rxFull), .transferDone(transferDone), .overrun(overrun), .irq(irq));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic pulse(input logic w, input logic r, input logic s);
      @(negedge clk);
      txWrite = w;
      rxRead = r;
      statusRead = s;
      @(negedge clk);
      txWrite = 1'b0;
      rxRead = 1'b0;
      statusRead = 1'b0;
   endtask : pulse
   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : stop_test
   always @(negedge clk) begin
      if (transferDone === 1'b1 && doneLast === 1'b0 && expQ.size() > 0) check(rxData, expQ.pop_front());
      doneLast <= transferDone;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         n_fail++;
         stop_test();
      end
   end
   initial begin
      repeat (20) @(negedge clk);
      reset = 1'b0;
      repeat (4) @(negedge clk);
      for (i = 0; i < 6; i++) begin
         spiMode = 2'(i);
         lsbFirst = 1'(i ^ (i >> 1));
         inputSyncSelect = 2'(i % 3);
         irqMode = irq_mode_t'(4'h1 << (i % 4));
         mo = 16'(rnd());
         ssSel = mo[1:0];
         mosiSel = mo[7:4];
         noise = 16'(rnd());
         tx = 8'(rnd());
         mo = 16'(rnd());
         txData = tx;
         pulse(1'b1, 1'b0, 1'b0);
         check({7'h00, txEmpty}, 8'h00);
         expQ.push_back(mo[7:0]);
         m.frame(spiMode, lsbFirst, 1, mo, mi);
         check(mi[7:0], tx);
         repeat (10) @(negedge clk);
         check(statusByte, 8'h38);
         pulse(1'b0, 1'b1, 1'b1);
         check(statusByte, 8'h10);
         $display("Byte test %0d over", i);
      end
      expQ.push_back(mo[7:0]);
      m.frame(spiMode, lsbFirst, 2, mo, mi);
      repeat (10) @(negedge clk);
      check({7'h00, overrun}, 8'h01);
      pulse(1'b0, 1'b1, 1'b1);
      $display("Overrun test over");
      enable = 1'b0;
      m.frame(spiMode, lsbFirst, 1, mo, mi);
      repeat (10) @(negedge clk);
      check(statusByte, 8'h10);
      $display("Disable test over");
      enable = 1'b1;
      txData = 8'hC3;
      pulse(1'b1, 1'b0, 1'b0);
      ssSel = 2'h0;
      fwMode = 1'b1;
      repeat (10) @(negedge clk);
      check({7'h00, txEmpty}, 8'h01);
      check({7'h00, miso}, 8'h01);
      fwMode = 1'b0;
      repeat (10) @(negedge clk);
      $display("Firmware select test over");
      stop_test();
   end
endmodule : spi_slave_byte_shifter_bench
bind spi_slave_byte_shifter spi_slave_props u_props (.clk(clk), .reset(reset), .ssInputsN(ssInputsN),
   .ssSourceSel(ssSourceSel), .enable(enable), .intEnable(intEnable), .irqMode(irqMode), .txWrite(txWrite),
   .rxRead(rxRead), .statusRead(statusRead), .rxData(rxData), .statusByte(statusByte), .txEmpty(txEmpty),
   .rxFull(rxFull), .transferDone(transferDone), .overrun(overrun), .irq(irq));
`default_nettype wire
